// >>> verilog/dtfd_decoder.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "dtfd_defines.svh"

module dtfd_decoder
  import dtfd_pkg::*;
#(
  parameter int NUM_TERM = 8,
  parameter int FREQ_W   = 16
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Terminals
  input  wire logic [NUM_TERM-1:0] term_in,
  // Motor control core
  input  wire logic [FREQ_W-1:0] run_freq,
  output dtfd_cmd_t              drive_cmd
);

  // ************************************************
  // Registers
  // ************************************************
  logic [31:0]             ctrl_q;
  logic [15:0]             updn_rate_q;
  logic [23:0]             brake_q;
  logic [23:0]             brake_dur_q;
  logic [63:0]             func_q;
  logic [31:0]             prdata_q;
  logic                    addr_ok;
  logic [31:0]             rd_val;
  dtfd_state_t             state_q;
  dtfd_state_t             state_d;
  dtfd_cmd_t               cmd_q;
  dtfd_cmd_t               cmd_d;
  logic [15:0]             updn_q;

  wire logic [1:0] cmd_src    = ctrl_q[`DTFD_CMD_SRC_LSB +: 2];
  wire logic [3:0] main_src   = ctrl_q[`DTFD_MAIN_SRC_LSB +: 4];
  wire logic [3:0] aux_src    = ctrl_q[`DTFD_AUX_SRC_LSB +: 4];
  wire logic [3:0] comb_sel   = ctrl_q[`DTFD_COMB_LSB +: 4];
  wire logic [3:0] three_mode = ctrl_q[`DTFD_THREE_WIRE_LSB +: 4];
  wire logic       seq_mode   = ctrl_q[`DTFD_SEQ_MODE_BIT];
  wire logic       term_ctl   = (cmd_src == `DTFD_CMD_TERMINAL);
  wire logic       apb_wr     = psel & penable & pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 32'h0000_0000;
    case (paddr)
      `DTFD_CTRL_OFS:      rd_val = ctrl_q;
      `DTFD_UPDN_RATE_OFS: rd_val = {16'h0000, updn_rate_q};
      `DTFD_BRAKE_OFS:     rd_val = {8'h00, brake_q};
      `DTFD_BRAKE_DUR_OFS: rd_val = {8'h00, brake_dur_q};
      `DTFD_FUNC_LO_OFS:   rd_val = func_q[31:0];
      `DTFD_FUNC_HI_OFS:   rd_val = func_q[63:32];
      `DTFD_STATUS_OFS:    rd_val = {16'h0000, cmd_q.ext_fault, cmd_q.ramp_set,
                                     cmd_q.speed_index, 2'h0, state_q};
      `DTFD_UPDN_VAL_OFS:  rd_val = {16'h0000, updn_q};
      default:             addr_ok = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = prdata_q;

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `DTFD_CTRL_RST;
      updn_rate_q <= `DTFD_UPDN_RATE_RST;
      brake_q     <= `DTFD_BRAKE_RST;
      brake_dur_q <= `DTFD_BRAKE_DUR_RST;
      func_q      <= {`DTFD_FUNC_RST, `DTFD_FUNC_RST};
    end else if (apb_wr) begin
      case (paddr)
        `DTFD_CTRL_OFS:      ctrl_q        <= pwdata;
        `DTFD_UPDN_RATE_OFS: updn_rate_q   <= pwdata[15:0];
        `DTFD_BRAKE_OFS:     brake_q       <= pwdata[23:0];
        `DTFD_BRAKE_DUR_OFS: brake_dur_q   <= pwdata[23:0];
        `DTFD_FUNC_LO_OFS:   func_q[31:0]  <= pwdata;
        `DTFD_FUNC_HI_OFS:   func_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // ************************************************
  // Synchroniser and function decode
  // ************************************************
  logic [NUM_TERM-1:0]     sync1_q;
  logic [NUM_TERM-1:0]     sync2_q;
  logic [`DTFD_FN_COUNT-1:0] term_act [NUM_TERM];
  logic [`DTFD_FN_COUNT-1:0] term_cfg [NUM_TERM];
  logic [`DTFD_FN_COUNT-1:0] fn;
  logic [`DTFD_FN_COUNT-1:0] fn_cfg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= term_in;
      sync2_q <= sync1_q;
    end
  end

  genvar t;
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_term
      wire logic [7:0] code = func_q[t*8 +: 8];
      always_comb begin
        term_cfg[t] = '0;
        if (code != 8'h00 && code < 8'(`DTFD_FN_COUNT)) begin
          term_cfg[t][code[5:0]] = 1'b1;
        end
        term_act[t] = sync2_q[t] ? term_cfg[t] : '0;
      end
    end
  endgenerate

  // A code on two terminals is simply ORed
  always_comb begin
    fn     = '0;
    fn_cfg = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      fn     = fn | term_act[i];
      fn_cfg = fn_cfg | term_cfg[i];
    end
  end

  // ************************************************
  // Run, jog and three-wire requests
  // ************************************************
  logic fwd_q;
  logic rev_q;
  logic latch_q;
  logic latch_rev_q;
  logic fault_rst_q;
  logic pause_q;

  wire logic three_wire = term_ctl && three_mode != 4'h0
                          && fn_cfg[`DTFD_FN_THREE_WIRE];
  wire logic fwd_rise   = fn[`DTFD_FN_FWD_RUN] & ~fwd_q;
  wire logic rev_rise   = fn[`DTFD_FN_REV_RUN] & ~rev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q       <= 1'b0;
      rev_q       <= 1'b0;
      latch_q     <= 1'b0;
      latch_rev_q <= 1'b0;
    end else begin
      fwd_q <= fn[`DTFD_FN_FWD_RUN];
      rev_q <= fn[`DTFD_FN_REV_RUN];
      if (!three_wire || !fn[`DTFD_FN_THREE_WIRE]) begin
        latch_q <= 1'b0;
      end else if (fwd_rise || rev_rise) begin
        latch_q     <= 1'b1;
        latch_rev_q <= rev_rise & ~fwd_rise;
      end
    end
  end

  wire logic run_req  = term_ctl && (three_wire ? latch_q
                        : (fn[`DTFD_FN_FWD_RUN] | fn[`DTFD_FN_REV_RUN]));
  wire logic run_rev  = three_wire ? latch_rev_q : ~fn[`DTFD_FN_FWD_RUN];
  wire logic jog_req  = term_ctl && (fn[`DTFD_FN_FWD_JOG] | fn[`DTFD_FN_REV_JOG]);
  wire logic jog_rev  = ~fn[`DTFD_FN_FWD_JOG];

  // ************************************************
  // Fault, coast and brake conditions
  // ************************************************
  wire logic fault_cond = fn[`DTFD_FN_EXT_FLT_NO]
                          | (fn_cfg[`DTFD_FN_EXT_FLT_NC]
                             & ~fn[`DTFD_FN_EXT_FLT_NC]);
  wire logic reset_rise = fn[`DTFD_FN_FLT_RESET] & ~fault_rst_q;
  wire logic below_brk  = run_freq < FREQ_W'(brake_q[15:0]);
  logic [23:0] brk_cnt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      DTFD_ST_STOP: begin
        if (fault_cond) state_d = DTFD_ST_FAULT;
        else if (run_req) state_d = DTFD_ST_RUN;
        else if (jog_req) state_d = DTFD_ST_JOG;
      end
      DTFD_ST_RUN: begin
        if (fault_cond) state_d = DTFD_ST_FAULT;
        else if (fn[`DTFD_FN_COAST]) state_d = DTFD_ST_COAST;
        else if (!run_req) state_d = DTFD_ST_DECEL;
      end
      DTFD_ST_JOG: begin
        if (fault_cond) state_d = DTFD_ST_FAULT;
        else if (!jog_req) state_d = DTFD_ST_DECEL;
      end
      DTFD_ST_DECEL: begin
        if (fault_cond) state_d = DTFD_ST_FAULT;
        else if (run_req) state_d = DTFD_ST_RUN;
        else if (fn[`DTFD_FN_DC_BRAKE] && below_brk) state_d = DTFD_ST_BRAKE;
        else if (run_freq == '0) state_d = DTFD_ST_STOP;
      end
      DTFD_ST_BRAKE: begin
        if (fault_cond) state_d = DTFD_ST_FAULT;
        else if (brk_cnt_q == 24'h00_0000 && !fn[`DTFD_FN_DC_BRAKE]) begin
          state_d = DTFD_ST_STOP;
        end
      end
      DTFD_ST_COAST: begin
        if (fault_cond) state_d = DTFD_ST_FAULT;
        else if (!fn[`DTFD_FN_COAST] && run_freq == '0) state_d = DTFD_ST_STOP;
      end
      DTFD_ST_FAULT: begin
        if (reset_rise && term_ctl && !fault_cond) state_d = DTFD_ST_STOP;
      end
      default: state_d = DTFD_ST_STOP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= DTFD_ST_STOP;
      fault_rst_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      fault_rst_q <= fn[`DTFD_FN_FLT_RESET];
    end
  end

  // Brake duration counter, loaded on entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cnt_q <= 24'h00_0000;
    end else if (state_q != DTFD_ST_BRAKE && state_d == DTFD_ST_BRAKE) begin
      brk_cnt_q <= brake_dur_q;
    end else if (state_q == DTFD_ST_BRAKE && brk_cnt_q != 24'h00_0000) begin
      brk_cnt_q <= brk_cnt_q - 24'h00_0001;
    end
  end

  // ************************************************
  // Frequency up/down
  // ************************************************
  logic [15:0] rate_cnt_q;
  wire logic   ud_ok   = (main_src == `DTFD_SRC_DIGITAL)
                         || (aux_src == `DTFD_SRC_DIGITAL);
  wire logic   ud_tick = (rate_cnt_q == 16'h0000);
  wire logic   ud_clr  = fn[`DTFD_FN_UD_CLR_T] | fn[`DTFD_FN_UD_CLR_TK];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_cnt_q <= 16'h0000;
    end else if (ud_tick) begin
      rate_cnt_q <= updn_rate_q;
    end else begin
      rate_cnt_q <= rate_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      updn_q <= 16'h0000;
    end else if (ud_clr) begin
      updn_q <= 16'h0000;
    end else if (ud_ok && ud_tick && !fn[`DTFD_FN_RAMP_HOLD]) begin
      if (fn[`DTFD_FN_UP] && !fn[`DTFD_FN_DOWN] && updn_q != 16'hffff) begin
        updn_q <= updn_q + 16'h0001;
      end else if (fn[`DTFD_FN_DOWN] && !fn[`DTFD_FN_UP] && updn_q != 16'h0000) begin
        updn_q <= updn_q - 16'h0001;
      end
    end
  end

  // ************************************************
  // Sequencer pause tracking
  // ************************************************
  wire logic moving = (state_q == DTFD_ST_RUN) || (state_q == DTFD_ST_JOG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_q <= 1'b0;
    end else begin
      pause_q <= fn[`DTFD_FN_SEQ_PAUSE] & moving;
    end
  end

  // ************************************************
  // Command outputs
  // ************************************************
  always_comb begin
    cmd_d               = cmd_q;
    cmd_d.run           = (state_d == DTFD_ST_RUN);
    cmd_d.jog           = (state_d == DTFD_ST_JOG);
    if (state_q == DTFD_ST_STOP && state_d == DTFD_ST_RUN) cmd_d.reverse = run_rev;
    if (state_q == DTFD_ST_STOP && state_d == DTFD_ST_JOG) cmd_d.reverse = jog_rev;
    cmd_d.coast         = (state_d == DTFD_ST_COAST) || (state_d == DTFD_ST_FAULT);
    cmd_d.ramp_hold     = fn[`DTFD_FN_RAMP_HOLD] && state_d == DTFD_ST_RUN;
    cmd_d.dc_brake      = (state_d == DTFD_ST_BRAKE);
    cmd_d.brake_current = brake_q[23:16];
    cmd_d.speed_valid   = (main_src == `DTFD_SRC_MULTISPEED);
    cmd_d.speed_index   = cmd_d.speed_valid
                          ? fn[`DTFD_FN_SPEED0 +: 4] : 4'h0;
    cmd_d.motor2        = fn[`DTFD_FN_MOTOR_SW];
    if (fn[`DTFD_FN_MOTOR_SW]) begin
      cmd_d.ramp_set = {1'b1, fn[`DTFD_FN_RAMP1]};
    end else if (fn_cfg[`DTFD_FN_MOTOR_SW]) begin
      cmd_d.ramp_set = {1'b0, fn[`DTFD_FN_RAMP0]};
    end else begin
      cmd_d.ramp_set = {fn[`DTFD_FN_RAMP1], fn[`DTFD_FN_RAMP0]};
    end
    cmd_d.ref_sel = DTFD_REF_DEFAULT;
    if (comb_sel <= `DTFD_COMB_MAX_AB) begin
      if (fn[`DTFD_FN_SW_A_B]) begin
        cmd_d.ref_sel = (comb_sel == 4'h0) ? DTFD_REF_AUX : DTFD_REF_MAIN;
      end
    end else if (comb_sel <= `DTFD_COMB_MAX_COMB) begin
      if (fn[`DTFD_FN_SW_COMB_A]) cmd_d.ref_sel = DTFD_REF_MAIN;
      else if (fn[`DTFD_FN_SW_COMB_B]) cmd_d.ref_sel = DTFD_REF_AUX;
    end
    cmd_d.updown_offset = updn_q;
    cmd_d.ext_fault     = (state_d == DTFD_ST_FAULT);
    cmd_d.seq_pause     = fn[`DTFD_FN_SEQ_PAUSE] & moving;
    cmd_d.speed_track   = pause_q & ~fn[`DTFD_FN_SEQ_PAUSE] & moving;
    cmd_d.seq_clear     = seq_mode && state_q == DTFD_ST_STOP && state_d == DTFD_ST_STOP
                          && fn[`DTFD_FN_SEQ_CLEAR];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  assign drive_cmd = cmd_q;

endmodule

// >>> verilog/dtfd_defines.svh
`ifndef DTFD_DEFINES_SVH
`define DTFD_DEFINES_SVH

// Register byte offsets
`define DTFD_CTRL_OFS        8'h00
`define DTFD_UPDN_RATE_OFS   8'h04
`define DTFD_BRAKE_OFS       8'h08
`define DTFD_BRAKE_DUR_OFS   8'h0c
`define DTFD_FUNC_LO_OFS     8'h10
`define DTFD_FUNC_HI_OFS     8'h14
`define DTFD_STATUS_OFS      8'h20
`define DTFD_UPDN_VAL_OFS    8'h24

// Control register fields
`define DTFD_CMD_SRC_LSB     0
`define DTFD_MAIN_SRC_LSB    8
`define DTFD_AUX_SRC_LSB     12
`define DTFD_COMB_LSB        16
`define DTFD_THREE_WIRE_LSB  20
`define DTFD_SEQ_MODE_BIT    24

// Reset values
`define DTFD_CTRL_RST        32'h0000_0000
`define DTFD_UPDN_RATE_RST   16'h03e8
`define DTFD_BRAKE_RST       24'h00_0000
`define DTFD_BRAKE_DUR_RST   24'h00_0000
`define DTFD_FUNC_RST        32'h0000_0000

// Setting values that enable functions
`define DTFD_CMD_TERMINAL    2'h1
`define DTFD_SRC_MULTISPEED  4'h5
`define DTFD_SRC_DIGITAL     4'h0
`define DTFD_COMB_MAX_AB     4'h1
`define DTFD_COMB_MIN_COMB   4'h2
`define DTFD_COMB_MAX_COMB   4'h5

// Terminal function codes
`define DTFD_FN_FWD_RUN      1
`define DTFD_FN_REV_RUN      2
`define DTFD_FN_FWD_JOG      3
`define DTFD_FN_REV_JOG      4
`define DTFD_FN_THREE_WIRE   5
`define DTFD_FN_SPEED0       6
`define DTFD_FN_RAMP0        10
`define DTFD_FN_RAMP1        11
`define DTFD_FN_UD_CLR_T     12
`define DTFD_FN_UD_CLR_TK    13
`define DTFD_FN_UP           14
`define DTFD_FN_DOWN         15
`define DTFD_FN_EXT_FLT_NO   16
`define DTFD_FN_EXT_FLT_NC   17
`define DTFD_FN_SW_A_B       20
`define DTFD_FN_SW_COMB_A    21
`define DTFD_FN_FLT_RESET    22
`define DTFD_FN_COAST        23
`define DTFD_FN_RAMP_HOLD    24
`define DTFD_FN_DC_BRAKE     25
`define DTFD_FN_SEQ_PAUSE    26
`define DTFD_FN_SW_COMB_B    27
`define DTFD_FN_SEQ_CLEAR    28
`define DTFD_FN_MOTOR_SW     55
`define DTFD_FN_COUNT        56

`endif

// >>> verilog/dtfd_pkg.sv
package dtfd_pkg;

  typedef enum logic [6:0] {
    DTFD_ST_STOP  = 7'b000_0001,
    DTFD_ST_RUN   = 7'b000_0010,
    DTFD_ST_JOG   = 7'b000_0100,
    DTFD_ST_DECEL = 7'b000_1000,
    DTFD_ST_BRAKE = 7'b001_0000,
    DTFD_ST_COAST = 7'b010_0000,
    DTFD_ST_FAULT = 7'b100_0000
  } dtfd_state_t;

  typedef enum logic [1:0] {
    DTFD_REF_DEFAULT = 2'h0,
    DTFD_REF_MAIN    = 2'h1,
    DTFD_REF_AUX     = 2'h2
  } dtfd_ref_t;

  // Command bundle to the motor control core
  typedef struct packed {
    logic        run;
    logic        jog;
    logic        reverse;
    logic        coast;
    logic        ramp_hold;
    logic        dc_brake;
    logic [7:0]  brake_current;
    logic        speed_valid;
    logic [3:0]  speed_index;
    logic [1:0]  ramp_set;
    logic        motor2;
    dtfd_ref_t   ref_sel;
    logic [15:0] updown_offset;
    logic        ext_fault;
    logic        seq_pause;
    logic        seq_clear;
    logic        speed_track;
  } dtfd_cmd_t;

endpackage

// >>> sim/dtfd_decoder_props.sv
`timescale 1ns/100ps
// ***
// Port checker
// ***
module dtfd_decoder_props
  import dtfd_pkg::*;
#(
  parameter int NUM_TERM = 8,
  parameter int FREQ_W   = 16
) (
  // Bus
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Terminals and core
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic [FREQ_W-1:0]   run_freq,
  input wire dtfd_cmd_t           drive_cmd
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic mapped(input logic [7:0] a);
    return a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
  endfunction

  sequence access_s;
    psel && penable;
  endsequence
  sequence xfer_s;
    psel && !penable ##1 access_s;
  endsequence

  AST_READY: assert property (access_s |-> pready)
    else $error("access phase without ready");
  AST_ERR: assert property (xfer_s |-> pslverr == !mapped(paddr))
    else $error("error response wrong for address");
  AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
    else $error("error response outside access");
  AST_RDATA: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved outside setup");
  AST_EXCL: assert property (!(drive_cmd.run && drive_cmd.jog))
    else $error("run and jog together");
  AST_COAST: assert property (drive_cmd.coast |-> !drive_cmd.run && !drive_cmd.jog)
    else $error("output driven while coasting");
  AST_FAULT: assert property (drive_cmd.ext_fault |-> drive_cmd.coast && !drive_cmd.run)
    else $error("fault without output removed");
  AST_SPEED: assert property (!drive_cmd.speed_valid |-> drive_cmd.speed_index == 4'h0)
    else $error("speed index without multi-speed source");
  AST_HOLD: assert property (drive_cmd.ramp_hold |-> drive_cmd.run)
    else $error("ramp hold outside run");
  AST_BRAKE: assert property (drive_cmd.dc_brake |-> !drive_cmd.run && !drive_cmd.coast)
    else $error("braking while driven");
  AST_TRACK: assert property (drive_cmd.speed_track |=> !drive_cmd.speed_track)
    else $error("tracking pulse too long");
  AST_CLEAR: assert property (drive_cmd.seq_clear |-> !drive_cmd.run && !drive_cmd.jog)
    else $error("sequencer clear while moving");
endmodule

bind dtfd_decoder dtfd_decoder_props #(.NUM_TERM(NUM_TERM), .FREQ_W(FREQ_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .term_in(term_in), .run_freq(run_freq), .drive_cmd(drive_cmd)
);

// >>> sim/dtfd_switch_bank.sv
`timescale 1ns/100ps
// ***
// Contacts with pull-down, switching to want after lag+1 cycles
// ***
module dtfd_switch_bank (
  // Clock
  input wire logic       clk,
  // Request
  input wire logic [7:0] want,
  input wire logic [7:0] lag,
  // Contacts
  output logic     [7:0] term_in
);
  logic [7:0] cnt_q;
  initial begin
    term_in = 8'h00;
    cnt_q   = 8'h00;
  end
  always @(posedge clk) begin
    if (term_in == want) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= lag) begin
      term_in <= want;
      cnt_q   <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
  import dtfd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, want, lag, term_in;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] run_freq, u;
  dtfd_cmd_t   drive_cmd;
  int          errors, tests_run, n;
  int          q[$];

  dtfd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .term_in(term_in), .run_freq(run_freq), .drive_cmd(drive_cmd));
  dtfd_switch_bank u_sw (.clk(pclk), .want(want), .lag(lag), .term_in(term_in));

  // ***
  // Helpers
  // ***
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int mref(int c, int s);
    if (c < 2) return s[0] ? ((c == 0) ? 2 : 1) : 0;
    return s[1] ? 1 : (s[2] ? 2 : 0);
  endfunction
  function int mramp(int m, int s);
    if (m == 1 && s[2]) return 2 + s[1];
    if (m == 1) return s[0];
    return s[1] * 2 + s[0];
  endfunction
  task test_done;
    $display("counts errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin errors++; test_done(); end
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task cfg(input logic [63:0] m);
    apb(1'b1, 8'h10, m[31:0]);
    apb(1'b1, 8'h14, m[63:32]);
  endtask
  task sw(input logic [7:0] v);
    @(posedge pclk);
    want <= v;
    repeat (lag + 6) @(posedge pclk);
    #1;
  endtask
  task wait_stop;
    n = 0;
    do begin apb(1'b0, 8'h20, 32'h0); n++; end while (rd[0] !== 1'b1 && n < 100);
    if (n >= 100) begin errors++; test_done(); end
  endtask
  task brake(input int hold);
    int k;
    sw(8'h21);
    @(posedge pclk);
    want <= 8'h20;
    k = 0;
    while (drive_cmd.dc_brake !== 1'b1 && k < 50) begin @(posedge pclk); #1; k++; end
    if (k >= 50) begin errors++; test_done(); end
    chk("brake_current", 32'h5a, drive_cmd.brake_current);
    n = 0;
    do begin
      @(posedge pclk);
      if (n == hold) want <= 8'h00;
      #1;
      n++;
    end while (drive_cmd.dc_brake === 1'b1 && n < 500);
    if (n >= 500) begin errors++; test_done(); end
    chk("brake_len", 1, n >= 19 && n > hold);
    wait_stop();
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    test_done();
  end

  // ***
  // Main sequence
  // ***
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; run_freq = 16'h0; want = 8'h00; lag = 8'h00; seed = 32'h8;
    errors = 0; tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", 8'h00, 32'h0);
    rdc("rate", 8'h04, 32'h3e8);
    rdc("brk", 8'h08, 32'h0);
    rdc("dur", 8'h0c, 32'h0);
    rdc("flo", 8'h10, 32'h0);
    rdc("fhi", 8'h14, 32'h0);
    rdc("status", 8'h20, 32'h1);
    u = rnd();
    apb(1'b1, 8'h04, {16'h0, u});
    rdc("rate_rw", 8'h04, {16'h0, u});
    apb(1'b1, 8'h30, rnd());
    chk("unmapped_err", 1, er);
    rdc("unmapped", 8'h30, 32'h0);
    $display("test registers done");
    cfg(64'h101a_1918_1703_0201);
    sw(8'h01);
    chk("run_keypad", 0, drive_cmd.run);
    apb(1'b1, 8'h00, 32'h0000_0501);
    sw(8'h01);
    chk("run", 1, drive_cmd.run);
    sw(8'h05);
    chk("jog_in_run", 0, drive_cmd.jog);
    sw(8'h00);
    wait_stop();
    sw(8'h04);
    chk("jog", 1, drive_cmd.jog);
    chk("jog_fwd", 0, drive_cmd.reverse);
    sw(8'h05);
    chk("run_in_jog", 0, drive_cmd.run);
    sw(8'h00);
    wait_stop();
    sw(8'h12);
    chk("hold", 1, drive_cmd.ramp_hold);
    sw(8'h10);
    chk("hold_stop", 0, drive_cmd.run);
    sw(8'h00);
    wait_stop();
    sw(8'h01);
    sw(8'h09);
    chk("coast", 1, drive_cmd.coast);
    sw(8'h00);
    wait_stop();
    sw(8'h01);
    sw(8'h41);
    chk("pause", 1, drive_cmd.seq_pause);
    @(posedge pclk);
    want <= 8'h01;
    er = 1'b0;
    repeat (12) begin @(posedge pclk); #1; if (drive_cmd.speed_track === 1'b1) er = 1'b1; end
    chk("track", 1, er);
    sw(8'h00);
    wait_stop();
    $display("test run and jog done");
    apb(1'b1, 8'h08, 32'h005a_0064);
    apb(1'b1, 8'h0c, 32'd20);
    run_freq <= 16'd50;
    brake(0);
    brake(60);
    run_freq <= 16'd0;
    $display("test braking done");
    sw(8'h80);
    chk("fault_no", 1, drive_cmd.ext_fault);
    sw(8'h10);
    cfg(64'h0f1c_0c11_161b_1514);
    apb(1'b1, 8'h00, 32'h0);
    sw(8'h18);
    chk("reset_keypad", 1, drive_cmd.ext_fault);
    sw(8'h10);
    apb(1'b1, 8'h00, 32'h1);
    sw(8'h18);
    chk("reset", 0, drive_cmd.ext_fault);
    sw(8'h00);
    chk("fault_nc", 1, drive_cmd.ext_fault);
    sw(8'h10);
    sw(8'h18);
    sw(8'h10);
    for (int c = 0; c < 6; c++) begin
      for (int s = 1; s < 5; s = s * 2) begin
        apb(1'b1, 8'h00, 32'h1 | (c << 16));
        sw(8'h10 | s[7:0]);
        chk("ref_sel", mref(c, s), drive_cmd.ref_sel);
      end
    end
    apb(1'b1, 8'h00, 32'h0100_0001);
    sw(8'h50);
    chk("seq_clear", 1, drive_cmd.seq_clear);
    apb(1'b1, 8'h00, 32'h1);
    sw(8'h50);
    chk("seq_keep", 0, drive_cmd.seq_clear);
    $display("test fault and reference done");
    for (int m = 0; m < 2; m++) begin
      cfg((m == 1) ? 64'h0e37_0b0a_0908_0706 : 64'h0e00_0b0a_0908_0706);
      for (int s = 0; s < 8; s++) begin
        sw(8'(s << 4));
        chk("ramp_set", mramp(m, s), drive_cmd.ramp_set);
        chk("motor2", m & s[2], drive_cmd.motor2);
      end
    end
    apb(1'b1, 8'h00, 32'h0000_0501);
    for (int i = 0; i < 16; i++) q.push_back(i);
    repeat (4) q.push_back(int'(rnd() & 32'hf));
    lag = 8'd5;
    while (q.size() > 0) begin
      n = q.pop_front();
      sw(8'(n));
      chk("speed_index", n, drive_cmd.speed_index);
      chk("speed_valid", 1, drive_cmd.speed_valid);
    end
    lag = 8'd0;
    apb(1'b1, 8'h00, 32'h1);
    sw(8'h0f);
    chk("speed_off", 0, drive_cmd.speed_index);
    apb(1'b1, 8'h04, 32'd4);
    sw(8'h80);
    repeat (40) @(posedge pclk);
    sw(8'h00);
    u = drive_cmd.updown_offset;
    chk("updown_step", 1, u != 16'h0);
    apb(1'b1, 8'h00, 32'h0000_3501);
    sw(8'h80);
    repeat (40) @(posedge pclk);
    sw(8'h00);
    chk("updown_keep", u, drive_cmd.updown_offset);
    cfg(64'h0000_0000_0002_0501);
    apb(1'b1, 8'h00, 32'h0010_0001);
    sw(8'h02);
    sw(8'h03);
    sw(8'h02);
    chk("three_wire_hold", 1, drive_cmd.run);
    sw(8'h00);
    chk("three_wire_stop", 0, drive_cmd.run);
    wait_stop();
    $display("test selection done");
    test_done();
  end
endmodule
